// *** rtl/mop_pkg.sv ***
// Package: shared constants for the muxed overhead port
// How it works
// [R01] Device updates outputs, samples inputs on rising edge
// [R02] Far logic captures and drives on falling edge
// [R03] Overhead clock runs gap free, 10 to 52 MHz
// [R04] Marker pulses one clock in every twelve
// [R05] Marker aligned with outputs, leads sampling three
// [R06] Chip reset low forces all port outputs low
// [R07] Slot position after marker names the channel
// [R08] Transmit works only in mode, not disabled
// [R09] Data and enable sampled three clocks after valid
// [R10] Active enable replaces own overhead bit
// [R11] Transmit valid means sampling three clocks later
// [R12] Transmit frame start marks bit before frame
// [R13] Receive valid qualifies frame start and data
// [R14] Receive frame start coincides with first bit
// [R15] Receive data carries channel bit when valid
// [R16] Disabled or unframed slot keeps valids low
// [R17] Slots count modulo twelve from the marker
package mop_pkg;
    localparam int         PORTS    = 12;    // Framer ports, one per slot
    localparam int         TX_LAT   = 3;     // Clocks from tx valid to sampling
    localparam logic [3:0] SLOT_ONE = 4'h0;  // Counter value emitted as slot one
    localparam logic [3:0] SLOT_END = 4'hB;  // Last counter value of a cycle
    localparam logic [3:0] PORT_CNT = 4'hC;  // Slots at or above carry nothing
    localparam int         RX_W     = 2;     // Receive word width
    localparam int         RX_BIT   = 0;     // Receive word: overhead bit
    localparam int         RX_SOF   = 1;     // Receive word: first bit of frame
    localparam int         TR_W     = 2;     // Transmit reply word width
    localparam int         TR_EN    = 0;     // Reply word: sampled enable
    localparam int         TR_DAT   = 1;     // Reply word: sampled data
    localparam logic       RST_VAL  = 1'b0;  // Reset value of every l_reg and s_reg flop
endpackage

// *** rtl/mop_xfer_if.sv ***
// Interface: one word crossing between two clock domains
`timescale 1ns/1ps
`default_nettype none
interface mop_xfer_if #(parameter int W = 1);
    logic         src_valid;
    logic [W-1:0] src_data;
    logic         src_busy;
    logic         dst_pending;
    logic [W-1:0] dst_data;
    logic         dst_take;
    modport core (input src_valid, src_data, dst_take, output src_busy, dst_pending, dst_data);
    modport src  (output src_valid, src_data, input src_busy);
    modport dst  (input dst_pending, dst_data, output dst_take);
endinterface
`default_nettype wire

// *** rtl/mop_sync.sv ***
// Two flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module mop_sync #(parameter int W = 1) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } mop_sync_t;
    mop_sync_t r_reg;
    mop_sync_t r_next;

    // No reset here: this also carries the reset itself into the link domain
    always_comb begin
        r_next.meta = d_i;
        r_next.sync = r_reg.meta;
    end

    always_ff @(posedge clk_i) begin
        r_reg <= r_next;
    end

    assign q_o = r_reg.sync;
endmodule // mop_sync
`default_nettype wire

// *** rtl/mop_xfer.sv ***
// Toggle handshake that moves one held word across clock domains
`timescale 1ns/1ps
`default_nettype none
module mop_xfer #(parameter int W = 1) (
    input  wire logic src_clk_i,
    input  wire logic src_resetn_i,
    input  wire logic dst_clk_i,
    input  wire logic dst_resetn_i,
    mop_xfer_if.core  x
);
    typedef struct packed {
        logic         req;
        logic         ack_meta;
        logic         ack_sync;
        logic [W-1:0] data;
    } mop_src_t;
    typedef struct packed {
        logic req_meta;
        logic req_sync;
        logic ack;
    } mop_dst_t;
    mop_src_t s_reg;
    mop_src_t s_next;
    mop_dst_t d_reg;
    mop_dst_t d_next;

    // Source: word stays frozen until the destination hands back the toggle
    always_comb begin
        s_next          = s_reg;
        s_next.ack_meta = d_reg.ack;
        s_next.ack_sync = s_reg.ack_meta;
        if (x.src_valid && (s_reg.req == s_reg.ack_sync)) begin
            s_next.req  = ~s_reg.req;
            s_next.data = x.src_data;
        end
        if (!src_resetn_i) begin
            s_next = '0;
        end
    end

    always_ff @(posedge src_clk_i) begin
        s_reg <= s_next;
    end

    // Destination: a take flips the acknowledge and frees the source
    always_comb begin
        d_next          = d_reg;
        d_next.req_meta = s_reg.req;
        d_next.req_sync = d_reg.req_meta;
        if (x.dst_take && (d_reg.req_sync != d_reg.ack)) begin
            d_next.ack = d_reg.req_sync;
        end
        if (!dst_resetn_i) begin
            d_next = '0;
        end
    end

    always_ff @(posedge dst_clk_i) begin
        d_reg <= d_next;
    end

    assign x.src_busy    = s_reg.req != s_reg.ack_sync;
    assign x.dst_pending = d_reg.req_sync != d_reg.ack;
    assign x.dst_data    = s_reg.data;  // Stable while pending
endmodule // mop_xfer
`default_nettype wire

// *** rtl/mop_muxed_port.sv ***
// Muxed overhead port: slot counter on the overhead clock, framer side on sys clock
`timescale 1ns/1ps
`default_nettype none
module mop_muxed_port (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        ovh_port_clock_i,
    input  wire logic [11:0] port_ds3e3_mode_i,
    input  wire logic [11:0] tx_frame_start_input_i,
    input  wire logic [11:0] rx_bit_stb_i,
    input  wire logic [11:0] rx_bit_i,
    input  wire logic [11:0] rx_sof_i,
    output logic      [11:0] rx_ready_o,
    input  wire logic [11:0] tx_req_i,
    input  wire logic [11:0] tx_req_sof_i,
    input  wire logic [11:0] tx_own_bit_i,
    output logic      [11:0] tx_ready_o,
    output logic      [11:0] tx_bit_stb_o,
    output logic      [11:0] tx_bit_o,
    output logic             slot_one_marker_o,
    output logic             tx_ovh_valid_out_o,
    output logic             tx_ovh_frame_start_out_o,
    output logic             rx_ovh_valid_out_o,
    output logic             rx_ovh_frame_start_out_o,
    output logic             rx_ovh_data_out_o,
    input  wire logic        tx_ovh_data_in_i,
    input  wire logic        tx_ovh_data_enable_in_i
);
    localparam int NP  = mop_pkg::PORTS;
    localparam int LAT = mop_pkg::TX_LAT;

    typedef struct packed {
        logic [NP-1:0] rx_ready;
        logic [NP-1:0] tx_ready;
        logic [NP-1:0] tx_stb;
        logic [NP-1:0] tx_bit;
        logic [NP-1:0] own;
    } mop_sys_t;

    typedef struct packed {
        logic [3:0]          cnt;
        logic                marker;
        logic                txv;
        logic                txsof;
        logic                rxv;
        logic                rxsof;
        logic                rxdat;
        logic [LAT-1:0]      pv;
        logic [LAT-1:0][3:0] pp;
    } mop_link_t;

    mop_sys_t  s_reg;
    mop_sys_t  s_next;
    mop_link_t l_reg;
    mop_link_t l_next;

    logic                          link_rstn;
    logic [NP-1:0]                 mode_l;
    logic [NP-1:0]                 tx_frame_start_input_l;
    logic [NP-1:0]                 en_l;
    logic [NP-1:0]                 rx_busy;
    logic [NP-1:0]                 rx_pend;
    logic [NP-1:0]                 rx_take;
    logic [NP-1:0][mop_pkg::RX_W-1:0] rx_word;
    logic [NP-1:0]                 tq_busy;
    logic [NP-1:0]                 tq_pend;
    logic [NP-1:0]                 tq_take;
    logic [NP-1:0]                 tq_word;
    logic [NP-1:0]                 tr_valid;
    logic [NP-1:0]                 tr_pend;
    logic [NP-1:0][mop_pkg::TR_W-1:0] tr_word;

    // Chip reset reaches the link side two overhead clocks late
    mop_sync #(.W(1)) u_rst_sync (
        .clk_i (ovh_port_clock_i),
        .d_i   (resetn_i),
        .q_o   (link_rstn)
    );

    // Port configuration levels are quasi static, plain level sync suffices
    mop_sync #(.W(2 * NP)) u_cfg_sync (
        .clk_i (ovh_port_clock_i),
        .d_i   ({port_ds3e3_mode_i, tx_frame_start_input_i}),
        .q_o   ({mode_l, tx_frame_start_input_l})
    );

    // Enabling the tx frame start input switches the overhead port off
    assign en_l = mode_l & ~tx_frame_start_input_l; // R08 R16

    // Three crossings per port: rx bit, tx request, tx reply
    for (genvar p = 0; p < NP; p++) begin : g_port
        mop_xfer_if #(.W(mop_pkg::RX_W)) rx_if ();
        mop_xfer_if #(.W(1))             tq_if ();
        mop_xfer_if #(.W(mop_pkg::TR_W)) tr_if ();

        assign rx_if.src_valid = rx_bit_stb_i[p] & s_reg.rx_ready[p];
        assign rx_if.src_data  = {rx_sof_i[p], rx_bit_i[p]};
        assign rx_if.dst_take  = rx_take[p];
        assign rx_busy[p]      = rx_if.src_busy;
        assign rx_pend[p]      = rx_if.dst_pending;
        assign rx_word[p]      = rx_if.dst_data;

        assign tq_if.src_valid = tx_req_i[p] & s_reg.tx_ready[p];
        assign tq_if.src_data  = tx_req_sof_i[p];
        assign tq_if.dst_take  = tq_take[p];
        assign tq_busy[p]      = tq_if.src_busy;
        assign tq_pend[p]      = tq_if.dst_pending;
        assign tq_word[p]      = tq_if.dst_data[0];

        // Sampled pins go straight into the held reply word
        assign tr_if.src_valid = tr_valid[p]; // R09
        assign tr_if.src_data  = {tx_ovh_data_in_i, tx_ovh_data_enable_in_i};
        assign tr_if.dst_take  = tr_pend[p];
        assign tr_pend[p]      = tr_if.dst_pending;
        assign tr_word[p]      = tr_if.dst_data;

        mop_xfer #(.W(mop_pkg::RX_W)) u_rx (
            .src_clk_i    (clk_sys_i),
            .src_resetn_i (resetn_i),
            .dst_clk_i    (ovh_port_clock_i),
            .dst_resetn_i (link_rstn),
            .x            (rx_if.core)
        );
        mop_xfer #(.W(1)) u_tq (
            .src_clk_i    (clk_sys_i),
            .src_resetn_i (resetn_i),
            .dst_clk_i    (ovh_port_clock_i),
            .dst_resetn_i (link_rstn),
            .x            (tq_if.core)
        );
        mop_xfer #(.W(mop_pkg::TR_W)) u_tr (
            .src_clk_i    (ovh_port_clock_i),
            .src_resetn_i (link_rstn),
            .dst_clk_i    (clk_sys_i),
            .dst_resetn_i (resetn_i),
            .x            (tr_if.core)
        );
    end

    // Link side: the counter free runs, the clock is assumed gap free
    always_comb begin : link_comb
        l_next   = l_reg;
        rx_take  = '0;
        tq_take  = '0;
        tr_valid = '0;
        l_next.cnt = (l_reg.cnt == mop_pkg::SLOT_END) ? mop_pkg::SLOT_ONE
                                                      : l_reg.cnt + 4'h1; // R03 R17
        l_next.marker = (|mode_l) && (l_reg.cnt == mop_pkg::SLOT_ONE); // R04 R05
        l_next.txv    = 1'b0;
        l_next.txsof  = 1'b0;
        l_next.rxv    = 1'b0;
        l_next.rxsof  = 1'b0;
        l_next.rxdat  = 1'b0;
        // Counter value is the channel index; all outputs share its edge
        if (l_reg.cnt < mop_pkg::PORT_CNT) begin // R07 R17
            l_next.rxv   = en_l[l_reg.cnt] & rx_pend[l_reg.cnt]; // R13 R16
            l_next.rxdat = l_next.rxv & rx_word[l_reg.cnt][mop_pkg::RX_BIT]; // R15
            l_next.rxsof = l_next.rxv & rx_word[l_reg.cnt][mop_pkg::RX_SOF]; // R14
            // Disabled ports still drain so a stale word cannot block later
            rx_take[l_reg.cnt] = rx_pend[l_reg.cnt];
            l_next.txv   = en_l[l_reg.cnt] & tq_pend[l_reg.cnt]; // R08 R11 R16
            l_next.txsof = l_next.txv & tq_word[l_reg.cnt]; // R12
            tq_take[l_reg.cnt] = tq_pend[l_reg.cnt];
        end
        // Three stage slot pipe ties the sampling edge to tx valid
        l_next.pv = {l_reg.pv[LAT-2:0], l_next.txv}; // R09 R11
        l_next.pp = {l_reg.pp[LAT-2:0], l_reg.cnt};
        if (l_reg.pv[LAT-1] && (l_reg.pp[LAT-1] < mop_pkg::PORT_CNT)) begin
            tr_valid[l_reg.pp[LAT-1]] = 1'b1; // R09 R10
        end
        if (!link_rstn) begin
            l_next = {$bits(mop_link_t){mop_pkg::RST_VAL}}; // R06
        end
    end

    always_ff @(posedge ovh_port_clock_i) begin : link_ff
        l_reg <= l_next; // R01
    end

    // Framer side: accept words, rebuild tx bit from reply and own bit
    always_comb begin : sys_comb
        s_next = s_reg;
        for (int p = 0; p < NP; p++) begin
            s_next.rx_ready[p] = !rx_busy[p] && !(rx_bit_stb_i[p] && s_reg.rx_ready[p]);
            if (tx_req_i[p] && s_reg.tx_ready[p]) begin
                s_next.own[p] = tx_own_bit_i[p];
            end
            s_next.tx_ready[p] = !tq_busy[p] && !(tx_req_i[p] && s_reg.tx_ready[p]);
            s_next.tx_stb[p]   = tr_pend[p];
            if (tr_pend[p]) begin
                s_next.tx_bit[p] = tr_word[p][mop_pkg::TR_EN] ? tr_word[p][mop_pkg::TR_DAT]
                                                              : s_reg.own[p]; // R10
            end
        end
        if (!resetn_i) begin
            s_next = {$bits(mop_sys_t){mop_pkg::RST_VAL}};
        end
    end

    always_ff @(posedge clk_sys_i) begin : sys_ff
        s_reg <= s_next;
    end

    assign rx_ready_o               = s_reg.rx_ready;
    assign tx_ready_o               = s_reg.tx_ready;
    assign tx_bit_stb_o             = s_reg.tx_stb;
    assign tx_bit_o                 = s_reg.tx_bit;
    assign slot_one_marker_o        = l_reg.marker;
    assign tx_ovh_valid_out_o       = l_reg.txv;
    assign tx_ovh_frame_start_out_o = l_reg.txsof;
    assign rx_ovh_valid_out_o       = l_reg.rxv;
    assign rx_ovh_frame_start_out_o = l_reg.rxsof;
    assign rx_ovh_data_out_o        = l_reg.rxdat;

    // Marker sits on counter value one, i.e. the slot after the wrap
    marker_slot_a: assert property ( // R05
        @(posedge ovh_port_clock_i) disable iff (!link_rstn)
        l_reg.marker |-> (l_reg.cnt == 4'h1))
        else $error("marker not aligned to slot one");

    marker_gap_a: assert property ( // R04
        @(posedge ovh_port_clock_i) disable iff (!link_rstn)
        l_reg.marker |=> (!l_reg.marker)[*8] ##1 (!l_reg.marker)[*3])
        else $error("marker repeated inside twelve clocks");

    marker_period_a: assert property ( // R17
        @(posedge ovh_port_clock_i) disable iff (!link_rstn)
        (l_reg.marker && $stable(mode_l)) |-> ##12 (l_reg.marker || !(|mode_l)))
        else $error("marker missing after twelve clocks");

    tx_sample_a: assert property ( // R09
        @(posedge ovh_port_clock_i) disable iff (!link_rstn)
        l_reg.txv |-> ##2 (|tr_valid))
        else $error("tx pins not sampled three clocks after valid");

    tx_no_sample_a: assert property ( // R11
        @(posedge ovh_port_clock_i) disable iff (!link_rstn)
        !l_reg.txv |-> ##2 !(|tr_valid))
        else $error("tx pins sampled without valid");

    tx_sof_valid_a: assert property ( // R12
        @(posedge ovh_port_clock_i) disable iff (!link_rstn)
        l_reg.txsof |-> l_reg.txv)
        else $error("tx frame start without valid");

    rx_sof_valid_a: assert property ( // R13
        @(posedge ovh_port_clock_i) disable iff (!link_rstn)
        (l_reg.rxsof || l_reg.rxdat) |-> l_reg.rxv)
        else $error("rx frame start or data without valid");

    slot_enable_a: assert property ( // R16
        @(posedge ovh_port_clock_i) disable iff (!link_rstn)
        ((l_reg.txv || l_reg.rxv) && $stable(en_l)) |-> en_l[$past(l_reg.cnt)])
        else $error("valid on a disabled slot");

    reset_quiet_a: assert property ( // R06
        @(posedge ovh_port_clock_i)
        !link_rstn |=> !(l_reg.marker || l_reg.txv || l_reg.txsof || l_reg.rxv
                         || l_reg.rxsof || l_reg.rxdat))
        else $error("port output high during reset");

    tx_replace_a: assert property ( // R10
        @(posedge clk_sys_i) disable iff (!resetn_i)
        tr_pend[0] |=> (tx_bit_stb_o[0] && (tx_bit_o[0] ==
            ($past(tr_word[0][mop_pkg::TR_EN]) ? $past(tr_word[0][mop_pkg::TR_DAT])
                                                : $past(s_reg.own[0])))))
        else $error("tx bit not rebuilt from reply");

    // Marker follows the counter and the synced mode bits, in both directions
    marker_exact_a: assert property ( // R04
        @(posedge ovh_port_clock_i) disable iff (!link_rstn)
        l_reg.marker == ((l_reg.cnt == 4'h1) && $past(|mode_l)))
        else $error("marker does not match slot one and mode");

    counter_step_a: assert property ( // R17
        @(posedge ovh_port_clock_i) disable iff (!link_rstn)
        (l_reg.cnt != mop_pkg::SLOT_ONE) |->
            ((l_reg.cnt <= mop_pkg::SLOT_END) && (l_reg.cnt == $past(l_reg.cnt) + 4'h1)))
        else $error("slot counter skipped a value");

    tx_valid_cause_a: assert property ( // R11
        @(posedge ovh_port_clock_i) disable iff (!link_rstn)
        l_reg.txv |-> $past(en_l[l_reg.cnt] && tq_pend[l_reg.cnt]))
        else $error("tx valid without an enabled pending request");

    // Independent of the slot pipe: the sampled slot is the one three edges back
    tx_pipe_slot_a: assert property ( // R07
        @(posedge ovh_port_clock_i) disable iff (!link_rstn)
        (|tr_valid) |-> tr_valid[$past(l_reg.cnt, 3)])
        else $error("tx pins sampled for the wrong slot");

    rx_data_match_a: assert property ( // R15
        @(posedge ovh_port_clock_i) disable iff (!link_rstn)
        l_reg.rxv |-> ((l_reg.rxdat == $past(rx_word[l_reg.cnt][mop_pkg::RX_BIT]))
            && (l_reg.rxsof == $past(rx_word[l_reg.cnt][mop_pkg::RX_SOF]))))
        else $error("rx data differs from the crossed word");

    sys_reset_quiet_a: assert property ( // R06
        @(posedge clk_sys_i)
        !resetn_i |=> !(|{rx_ready_o, tx_ready_o, tx_bit_stb_o, tx_bit_o}))
        else $error("framer side output high during reset");

    tx_stb_pulse_a: assert property ( // R10
        @(posedge clk_sys_i) disable iff (!resetn_i)
        tx_bit_stb_o[0] |=> !tx_bit_stb_o[0])
        else $error("tx bit strobe longer than one cycle");
endmodule // mop_muxed_port
`default_nettype wire

// *** testbench/mop_ovh_partner.sv ***
// Behavioural far-side overhead logic: captures and drives on the falling edge
`timescale 1ns/1ps
`default_nettype none
module mop_ovh_partner (
    input  wire logic        ovh_port_clock_i,
    input  wire logic        clr_i,
    input  wire logic        marker_i,
    input  wire logic        tx_valid_i,
    input  wire logic        tx_sof_i,
    input  wire logic        rx_valid_i,
    input  wire logic        rx_sof_i,
    input  wire logic        rx_data_i,
    input  wire logic [11:0] en_mask_i,
    input  wire logic [11:0] dat_mask_i,
    output logic             tx_data_o,
    output logic             tx_en_o,
    output logic      [11:0] rx_hit_o,
    output logic      [11:0] rx_bit_o,
    output logic      [11:0] rx_sof_o,
    output logic      [11:0] tx_hit_o,
    output logic      [11:0] tx_sof_o,
    output logic      [11:0] period_err_o
);
    int         slot = 0;
    int         gap = 0;
    int         spipe [2];
    logic       seen = 1'h0;
    logic [1:0] vpipe = 2'h0;
    initial begin
        tx_data_o = 1'h0;
        tx_en_o = 1'h0;
        rx_hit_o = 12'h000;
        tx_hit_o = 12'h000;
        period_err_o = 12'h000;
    end
    // Replies go out two falls after valid so they stand at the third rising edge
    always @(negedge ovh_port_clock_i) begin
        if (clr_i) begin
            rx_hit_o = 12'h000;
            tx_hit_o = 12'h000;
            seen = 1'h0;
        end
        slot = marker_i ? 0 : (slot + 1) % 12;
        if (marker_i) begin
            if (seen && gap != 11) period_err_o = period_err_o + 12'h001;
            seen = 1'h1;
            gap = 0;
        end else begin
            gap = gap + 1;
        end
        if (vpipe[1]) begin
            tx_en_o = en_mask_i[spipe[1]];
            tx_data_o = dat_mask_i[spipe[1]];
        end else begin
            // Outside the sampling slot the lines keep moving, never a stale value
            tx_en_o = ~tx_en_o;
            tx_data_o = ~tx_data_o;
        end
        vpipe = {vpipe[0], tx_valid_i};
        spipe[1] = spipe[0];
        spipe[0] = slot;
        if (tx_valid_i) begin
            tx_hit_o[slot] = 1'h1;
            tx_sof_o[slot] = tx_sof_i;
        end
        if (rx_valid_i) begin
            rx_hit_o[slot] = 1'h1;
            rx_bit_o[slot] = rx_data_i;
            rx_sof_o[slot] = rx_sof_i;
        end
    end
endmodule // mop_ovh_partner
`default_nettype wire

// *** testbench/mop_muxed_port_test.sv ***
// Self-checking bench for the muxed overhead port
`timescale 1ns/1ps
`default_nettype none
module mop_muxed_port_test;
    logic        clk_sys_i = 1'h0;
    logic        ovh_clk   = 1'h0;
    logic        resetn_i  = 1'h0;
    logic        clr       = 1'h0;
    logic        got;
    logic [5:0]  acc;
    logic [11:0] mode = 12'hFFF, dis = 12'h000, rstb = 12'h000, rbit = 12'h000;
    logic [11:0] rsof = 12'h000, treq = 12'h000, tsof = 12'h000, town = 12'h000;
    logic [11:0] en_mask, dat_mask;
    wire  [11:0] rx_ready, tx_ready, tx_stb, tx_bit;
    wire  [11:0] rx_hit, rx_got, rx_sofg, tx_hit, tx_sofg, perr;
    wire         marker, txv, txsofo, rxv, rxsofo, rxd, pdat, pen;
    int          mismatches = 0;
    int          samples_checked = 0;
    // Row columns: enable, data, own bit, tx frame start, rx bit, rx frame start
    logic [5:0]  rows [12] = '{6'h3A, 6'h15, 6'h2C, 6'h07, 6'h31, 6'h1E,
                               6'h28, 6'h13, 6'h3F, 6'h00, 6'h26, 6'h19};

    mop_muxed_port u_mop_muxed_port (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .ovh_port_clock_i(ovh_clk), .port_ds3e3_mode_i(mode), .tx_frame_start_input_i(dis),
        .rx_bit_stb_i(rstb), .rx_bit_i(rbit), .rx_sof_i(rsof), .rx_ready_o(rx_ready),
        .tx_req_i(treq), .tx_req_sof_i(tsof), .tx_own_bit_i(town), .tx_ready_o(tx_ready),
        .tx_bit_stb_o(tx_stb), .tx_bit_o(tx_bit), .slot_one_marker_o(marker),
        .tx_ovh_valid_out_o(txv), .tx_ovh_frame_start_out_o(txsofo), .rx_ovh_valid_out_o(rxv),
        .rx_ovh_frame_start_out_o(rxsofo), .rx_ovh_data_out_o(rxd),
        .tx_ovh_data_in_i(pdat), .tx_ovh_data_enable_in_i(pen));
    mop_ovh_partner u_mop_ovh_partner (.ovh_port_clock_i(ovh_clk), .clr_i(clr),
        .marker_i(marker), .tx_valid_i(txv), .tx_sof_i(txsofo), .rx_valid_i(rxv),
        .rx_sof_i(rxsofo), .rx_data_i(rxd), .en_mask_i(en_mask), .dat_mask_i(dat_mask),
        .tx_data_o(pdat), .tx_en_o(pen), .rx_hit_o(rx_hit), .rx_bit_o(rx_got),
        .rx_sof_o(rx_sofg), .tx_hit_o(tx_hit), .tx_sof_o(tx_sofg), .period_err_o(perr));

    // Two unrelated clocks: 4 ns system, 15 ns overhead link
    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #3.3;
        forever #7.5 ovh_clk = ~ovh_clk;
    end

    task automatic check_bit(input string what, input logic exp, input logic seen);
        samples_checked++;
        if (exp !== seen) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic check_vec(input string what, input logic [11:0] exp, input logic [11:0] seen);
        samples_checked++;
        if (exp !== seen) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic sys_cycles(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // Partner tallies are cleared over more than one link period so a fall sees it
    task automatic clear_partner();
        clr <= 1'h1;
        sys_cycles(5);
        clr <= 1'h0;
    endtask
    // One rx word and one tx request on port p, once both readies are up or after 200 cycles of waiting
    task automatic send(input int p, input logic [5:0] r);
        int k;
        k = 0;
        while (!(tx_ready[p] === 1'h1 && rx_ready[p] === 1'h1) && k < 200) begin
            @(negedge clk_sys_i);
            k++;
        end
        check_bit("ready before send", 1'h1, tx_ready[p] & rx_ready[p]);
        @(posedge clk_sys_i);
        rstb[p] <= 1'h1;
        rbit[p] <= r[1];
        rsof[p] <= r[0];
        treq[p] <= 1'h1;
        tsof[p] <= r[2];
        town[p] <= r[3];
        @(posedge clk_sys_i);
        rstb <= 12'h000;
        treq <= 12'h000;
    endtask
    task automatic wait_stb(input int p, input int n, output logic hit);
        hit = 1'h0;
        repeat (n) begin
            @(negedge clk_sys_i);
            if (tx_stb[p] === 1'h1) begin
                hit = 1'h1;
                break;
            end
        end
    endtask
    // OR of every link output, sampled mid-period where they are settled
    task automatic link_or(input int n, output logic [5:0] a);
        a = 6'h00;
        repeat (n) begin
            @(negedge ovh_clk);
            a = a | {rxd, rxsofo, rxv, txsofo, txv, marker};
        end
    endtask

    // A clean run needs roughly 11 us, so this span only trips on a hang
    initial begin
        #100us;
        mismatches++;
        $display("[ERR] watchdog expected done seen hang");
        conclude();
    end

    initial begin
        for (int i = 0; i < 12; i++) begin
            en_mask[i] = rows[i][5];
            dat_mask[i] = rows[i][4];
        end
        // Reset spans several link edges since the link side sees it through a sync
        sys_cycles(16);
        link_or(3, acc);
        check_vec("outputs in reset", 12'h000, {6'h00, acc});
        check_vec("sys in reset", 12'h000, rx_ready | tx_ready | tx_stb | tx_bit);
        @(posedge clk_sys_i);
        resetn_i <= 1'h1;
        sys_cycles(40);
        // Ordinary cases: one row per port, so every slot is exercised
        for (int p = 0; p < 12; p++) begin
            clear_partner();
            send(p, rows[p]);
            wait_stb(p, 400, got);
            check_bit("tx reply", 1'h1, got);
            check_bit("tx bit", rows[p][5] ? rows[p][4] : rows[p][3], tx_bit[p]);
            sys_cycles(80);
            check_vec("rx slots", 12'h001 << p, rx_hit);
            check_bit("rx data", rows[p][1], rx_got[p]);
            check_bit("rx sof", rows[p][0], rx_sofg[p]);
            check_vec("tx slots", 12'h001 << p, tx_hit);
            check_bit("tx sof", rows[p][2], tx_sofg[p]);
        end
        check_vec("marker period errors", 12'h000, perr);
        // Disabled port, then a port out of framing mode: no exchange at all
        for (int i = 0; i < 2; i++) begin
            if (i == 0) dis[3] <= 1'h1;
            else mode[7] <= 1'h0;
            sys_cycles(40);
            clear_partner();
            send(i == 0 ? 3 : 7, 6'h3F);
            wait_stb(i == 0 ? 3 : 7, 300, got);
            check_bit("refused reply", 1'h0, got);
            check_vec("refused tx slots", 12'h000, tx_hit);
            check_vec("refused rx slots", 12'h000, rx_hit);
            @(posedge clk_sys_i);
            dis <= 12'h000;
            mode <= 12'hFFF;
            @(posedge clk_sys_i);
        end
        // No port in mode: marker and valids stay silent, then the marker returns
        mode <= 12'h000;
        sys_cycles(40);
        link_or(30, acc);
        check_vec("silent link", 12'h000, {6'h00, acc});
        @(posedge clk_sys_i);
        mode <= 12'hFFF;
        sys_cycles(40);
        link_or(13, acc);
        check_bit("marker back", 1'h1, acc[0]);
        // Reset in mid-run forces the link outputs low again
        @(posedge clk_sys_i);
        resetn_i <= 1'h0;
        sys_cycles(16);
        link_or(12, acc);
        check_vec("outputs in second reset", 12'h000, {6'h00, acc});
        check_vec("sys in second reset", 12'h000, rx_ready | tx_ready | tx_stb | tx_bit);
        @(posedge clk_sys_i);
        resetn_i <= 1'h1;
        sys_cycles(40);
        link_or(13, acc);
        check_bit("marker after reset", 1'h1, acc[0]);
        check_vec("ready after reset", 12'hFFF, rx_ready & tx_ready);
        conclude();
    end
endmodule // mop_muxed_port_test
`default_nettype wire
